/* File: inc/adc_cfg_pkg.sv */
/*
 * Shared constants and carriers for the converter configuration bank:
 * register addresses, storage masks, field positions, pattern codes and
 * the packed structs that carry serial pins and decoded settings.
 * Assumes one bank of 8-bit registers behind a 16-bit serial write word.
 */
package adc_cfg_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register map
    localparam int NUM_REGS = 15;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int IDX_CTRL = 0;
    localparam int IDX_SWING = 1;
    localparam int IDX_PERF1 = 2;
    localparam int IDX_GAIN = 3;
    localparam int IDX_DRIVE = 4;
    localparam int IDX_FMT = 5;
    localparam int IDX_UPAT_HI = 6;
    localparam int IDX_UPAT_LO = 7;
    localparam int IDX_CLKRISE = 8;
    localparam int IDX_CLKFALL = 9;
    localparam int IDX_PWR = 10;
    localparam int IDX_PERF2 = 11;
    localparam int IDX_PEDESTAL = 12;
    localparam int IDX_OFSLOOP = 13;
    localparam int IDX_SLOW = 14;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    // Address of each stored register, in index order
    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        8'h00, 8'h01, 8'h03, 8'h25, 8'h26, 8'h3d, 8'h3f, 8'h40,
        8'h41, 8'h42, 8'h43, 8'h4a, 8'hbf, 8'hcf, 8'hdf};
    // Bits that hold state; fixed-zero positions are never stored
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{
        8'h01, 8'hfc, 8'h03, 8'hff, 8'h03, 8'he0, 8'hff, 8'hfc,
        8'hff, 8'hcc, 8'h53, 8'h01, 8'hfc, 8'hbc, 8'h30};

    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_READOUT_BIT = 0;
    localparam int CTRL_SWRESET_BIT = 1;
    localparam int GAIN_BYPASS_BIT = 3;
    localparam int DRV_DATA_BIT = 0;
    localparam int DRV_CLK_BIT = 1;
    localparam int FMT_OFS_EN_BIT = 5;
    localparam int LAT_SHORT_OFF_BIT = 3;
    localparam int LAT_SLEEP_BIT = 2;
    localparam int PWR_FULL_OFF_BIT = 6;
    localparam int PWR_DRV_OFF_BIT = 4;
    localparam int PERF2_BIT = 0;
    localparam int OFS_HOLD_BIT = 7;
    localparam logic [1:0] SWING_ENABLE_ON = 2'h3;
    localparam logic [5:0] SWING_DEFAULT = 6'h00;

    ////////////////////////////////////////////////////////////////////
    // Test pattern codes and data path constants
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_ZEROS = 3'h1;
    localparam logic [2:0] PAT_ONES = 3'h2;
    localparam logic [2:0] PAT_TOGGLE = 3'h3;
    localparam logic [2:0] PAT_RAMP = 3'h4;
    localparam logic [2:0] PAT_CUSTOM = 3'h5;
    localparam logic [3:0] GAIN_MAX_CODE = 4'hc;
    localparam int GAIN_FRAC = 12;
    localparam logic [1:0] RAMP_SLOW_LAST = 2'h3;
    localparam logic [3:0] SER_ADDR_LAST = 4'h7;
    localparam logic [3:0] SER_WORD_LAST = 4'hf;

    ////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic serialSelectN;
        logic serialClock;
        logic serialInLine;
    } ser_pins_t;

    typedef struct packed {
        logic [5:0] swingCode;
        logic clockBufferDoubleDrive;
        logic dataBufferDoubleDrive;
        logic [1:0] performanceModeOneField;
        logic performanceModeTwoBit;
        logic shortPathOff;
        logic lightSleep;
        logic fullPowerOff;
        logic outputDriverOff;
        logic offsetLoopEnable;
        logic offsetLoopHold;
        logic [3:0] offsetLoopSpeed;
        logic [1:0] dataFormat;
    } cfg_t;

endpackage : adc_cfg_pkg

/* File: design/two_entry_buffer.sv */
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
module two_entry_buffer #(
    parameter int WIDTH = 14
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);

    if (WIDTH < 1) begin : gWidthCheck
        $error("two_entry_buffer: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] slot_r [2]; // Storage, written at wrPtr
    logic wrPtr_r; // Next slot to fill
    logic rdPtr_r; // Oldest slot
    logic [1:0] count_r; // Entries held, 0..2
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    // Full stalls the source; empty hides stale data
    assign inReady = (count_r != 2'h2);
    assign outValid = (count_r != 2'h0);
    assign outData = slot_r[rdPtr_r];

    ////////////////////////////////////////////////////////////////////
    // Pointers and occupancy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_r <= ~wrPtr_r;
            end
            if (pop) begin
                rdPtr_r <= ~rdPtr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Slot storage needs no reset; outValid masks it
    always_ff @(posedge clk) begin
        if (push) begin
            slot_r[wrPtr_r] <= inData;
        end
    end

endmodule : two_entry_buffer

/* File: design/adc_serial_config.sv */
/*
 * Configuration register bank of the converter: three-wire serial write
 * port, serial read-back on the shared over-range pin, decoded settings,
 * digital gain and test pattern generator in front of a two-entry buffer.
 * Assumes serial pins and the reset pin are asynchronous to clk and that
 * the serial clock is far slower than clk (clk samples it).
 */

module adc_serial_config
    import adc_cfg_pkg::*;
#(
    parameter int DATA_W = 14
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire adc_cfg_pkg::ser_pins_t serPins,
    input wire logic resetPin,
    input wire logic [DATA_W-1:0] adcData,
    input wire logic adcValid,
    output logic adcReady,
    input wire logic overRange,
    output logic [DATA_W-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    output logic overrangeOrReadbackPin,
    output adc_cfg_pkg::cfg_t cfg
);
    import adc_cfg_pkg::*;

    if (DATA_W != 12 && DATA_W != 14) begin : gWidthCheck
        $error("adc_serial_config: DATA_W must be 12 or 14");
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first stage feeds only the second
    logic [3:0] syncA_r; // First stage
    logic [3:0] syncB_r; // Second stage, safe to use
    logic sclkLast_r; // Previous synced serial clock

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_r <= 4'h1;
            syncB_r <= 4'h1;
            sclkLast_r <= 1'b0;
        end else begin
            syncA_r <= {serPins.serialClock, serPins.serialInLine,
                        resetPin, serPins.serialSelectN};
            syncB_r <= syncA_r;
            sclkLast_r <= syncB_r[3];
        end
    end

    wire selN = syncB_r[0]; // Serial select, active low
    wire hwReset = syncB_r[1]; // Reset pin, active high
    wire sdIn = syncB_r[2]; // Serial data
    // Falling serial clock edge inside a frame
    wire sclkFall = sclkLast_r && !syncB_r[3] && !selN;

    ////////////////////////////////////////////////////////////////////
    // Serial word capture
    logic [3:0] bitCnt_r; // Edges seen in the current word
    logic [14:0] shift_r; // Bits received so far, MSB first
    logic [7:0] rbShift_r; // Read-back data, MSB on the pin

    wire addrDone = sclkFall && (bitCnt_r == SER_ADDR_LAST);
    wire wordDone = sclkFall && (bitCnt_r == SER_WORD_LAST);
    wire [7:0] rxAddr = shift_r[14:7]; // Address at word end
    wire [7:0] rxData = {shift_r[6:0], sdIn}; // Data at word end
    wire [7:0] rbAddr = {shift_r[6:0], sdIn}; // Address at 8th edge

    // Counter restarts whenever select goes high; extra bits past a
    // multiple of 16 never reach a 16th edge and are dropped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bitCnt_r <= 4'h0;
            shift_r <= 15'h0000;
        end else if (selN) begin
            bitCnt_r <= 4'h0;
        end else if (sclkFall) begin
            bitCnt_r <= bitCnt_r + 4'h1;
            shift_r <= {shift_r[13:0], sdIn};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register bank
    logic [7:0] regs_r [NUM_REGS]; // Stored bits only
    logic [NUM_REGS-1:0] wrHit; // Per-register write strobe

    // Read-back value of an address; unmapped and address 0 read zero
    function automatic logic [7:0] regRead(input logic [7:0] addr,
                                           input logic [7:0] r [NUM_REGS]);
        logic [7:0] v;
        v = 8'h00;
        for (int k = 1; k < NUM_REGS; k++) begin
            if (addr == REG_ADDR[k]) begin
                v = r[k];
            end
        end
        return v;
    endfunction : regRead

    wire readout = regs_r[IDX_CTRL][CTRL_READOUT_BIT];
    // Only address 0 may be written while read-back is on
    wire wrOpen = !readout || (rxAddr == ADDR_CTRL);
    // Software reset: write to address 0 with the reset bit high
    wire swReset = wordDone && wrOpen && (rxAddr == ADDR_CTRL)
                   && rxData[CTRL_SWRESET_BIT];
    wire clrAll = hwReset || swReset;

    // One strobe per register; no hit at all for unmapped addresses
    for (genvar i = 0; i < NUM_REGS; i++) begin : gRegs
        assign wrHit[i] = wordDone && wrOpen
                          && (rxAddr == REG_ADDR[i]);

        // Whole byte lands in one edge; reset bit itself is never kept
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                regs_r[i] <= REG_RESET;
            end else if (clrAll) begin
                regs_r[i] <= REG_RESET;
            end else if (wrHit[i]) begin
                regs_r[i] <= rxData & REG_MASK[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read-back shifter and shared pin
    // Loaded at the address edge so D7 is on the pin before the host
    // samples it on the next falling edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rbShift_r <= 8'h00;
        end else if (addrDone) begin
            rbShift_r <= regRead(rbAddr, regs_r);
        end else if (sclkFall) begin
            rbShift_r <= {rbShift_r[6:0], 1'b0};
        end
    end

    // Pin comes straight from a flop in both uses
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overrangeOrReadbackPin <= 1'b0;
        end else if (readout) begin
            overrangeOrReadbackPin <= rbShift_r[7];
        end else begin
            overrangeOrReadbackPin <= overRange;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decoded settings
    wire [1:0] swingEn = regs_r[IDX_PWR][1:0];
    wire swingOn = (swingEn == SWING_ENABLE_ON);
    wire shortOff = regs_r[IDX_CLKFALL][LAT_SHORT_OFF_BIT];

    // Settings register once more so they change on one edge together
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= '0;
        end else begin
            cfg.swingCode <= swingOn ? regs_r[IDX_SWING][7:2]
                                     : SWING_DEFAULT;
            cfg.clockBufferDoubleDrive <=
                regs_r[IDX_DRIVE][DRV_CLK_BIT];
            cfg.dataBufferDoubleDrive <=
                regs_r[IDX_DRIVE][DRV_DATA_BIT];
            // Codes 01/10 are passed through untouched; host avoids them
            cfg.performanceModeOneField <= regs_r[IDX_PERF1][1:0];
            cfg.performanceModeTwoBit <= regs_r[IDX_PERF2][PERF2_BIT];
            cfg.shortPathOff <= shortOff;
            cfg.lightSleep <= regs_r[IDX_CLKFALL][LAT_SLEEP_BIT];
            cfg.fullPowerOff <= regs_r[IDX_PWR][PWR_FULL_OFF_BIT];
            cfg.outputDriverOff <= regs_r[IDX_PWR][PWR_DRV_OFF_BIT];
            cfg.offsetLoopEnable <=
                regs_r[IDX_FMT][FMT_OFS_EN_BIT] && shortOff;
            cfg.offsetLoopHold <= regs_r[IDX_OFSLOOP][OFS_HOLD_BIT];
            cfg.offsetLoopSpeed <= regs_r[IDX_OFSLOOP][5:2];
            cfg.dataFormat <= regs_r[IDX_FMT][7:6];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Digital gain
    // Q2.12 factors for 0..6 dB in 0.5 dB steps; codes past 6 dB give 0 dB
    function automatic logic [13:0] gainFactor(input logic [3:0] code);
        logic [13:0] f;
        case (code)
            4'h1: f = 14'h10f3;
            4'h2: f = 14'h11f4;
            4'h3: f = 14'h1304;
            4'h4: f = 14'h1425;
            4'h5: f = 14'h1556;
            4'h6: f = 14'h169a;
            4'h7: f = 14'h17f1;
            4'h8: f = 14'h195c;
            4'h9: f = 14'h1add;
            4'ha: f = 14'h1c74;
            4'hb: f = 14'h1e24;
            4'hc: f = 14'h1fed;
            default: f = 14'h1000;
        endcase
        return f;
    endfunction : gainFactor

    localparam int PW = DATA_W + 15; // Product width
    localparam logic signed [PW-1:0] SAT_HI = PW'(2 ** (DATA_W - 1) - 1);
    localparam logic signed [PW-1:0] SAT_LO = -SAT_HI - PW'(1);

    wire [3:0] gainCode = regs_r[IDX_GAIN][7:4];
    // Gain only with bypass clear and low latency off
    wire gainOn = !regs_r[IDX_GAIN][GAIN_BYPASS_BIT] && shortOff
                  && (gainCode <= GAIN_MAX_CODE);
    wire signed [PW-1:0] gainProd =
        PW'($signed(adcData) * $signed({1'b0, gainFactor(gainCode)}));
    wire signed [PW-1:0] gainShift = gainProd >>> GAIN_FRAC;
    // Saturate instead of wrapping so large gains clip cleanly
    wire [DATA_W-1:0] gainSat =
        (gainShift > SAT_HI) ? SAT_HI[DATA_W-1:0] :
        (gainShift < SAT_LO) ? SAT_LO[DATA_W-1:0] :
        gainShift[DATA_W-1:0];
    wire [DATA_W-1:0] gained = gainOn ? gainSat : adcData;

    ////////////////////////////////////////////////////////////////////
    // Test pattern generator
    logic [DATA_W-1:0] ramp_r; // Ramp value, wraps at full scale
    logic [1:0] rampDiv_r; // Prescaler for the 12-bit ramp
    logic togglePh_r; // Low when the next toggle word is 0101

    wire [2:0] patSel = regs_r[IDX_GAIN][2:0];
    wire [13:0] userPat = {regs_r[IDX_UPAT_HI],
                           regs_r[IDX_UPAT_LO][7:2]};
    wire [DATA_W-1:0] toggleWord =
        {(DATA_W / 2){togglePh_r ? 2'h2 : 2'h1}};
    wire rampStep = (DATA_W == 14) ? 1'b1 :
                    (rampDiv_r == RAMP_SLOW_LAST);

    // Patterns replace samples only while low latency is off;
    // unused codes fall back to normal data
    logic [DATA_W-1:0] patWord; // Word loaded into the output stage
    always_comb begin
        patWord = gained;
        if (shortOff) begin
            case (patSel)
                PAT_ZEROS: patWord = '0;
                PAT_ONES: patWord = '1;
                PAT_TOGGLE: patWord = toggleWord;
                PAT_RAMP: patWord = ramp_r;
                PAT_CUSTOM: patWord = userPat[13 -: DATA_W];
                default: patWord = gained;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output stage and buffer
    logic [DATA_W-1:0] stgData_r; // Processed sample
    logic stgValid_r; // Stage holds a word
    logic bufInReady; // Buffer can take the stage word

    // Stage moves when empty or draining; a stall reaches adcReady
    assign adcReady = !stgValid_r || bufInReady;
    wire take = adcValid && adcReady;

    // Pattern counters advance once per accepted sample; the 12-bit ramp only on every fourth
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ramp_r <= '0;
            rampDiv_r <= 2'h0;
            togglePh_r <= 1'b0;
        end else if (take) begin
            togglePh_r <= ~togglePh_r;
            rampDiv_r <= rampDiv_r + 2'h1;
            if (rampStep) begin
                ramp_r <= ramp_r + DATA_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stgValid_r <= 1'b0;
            stgData_r <= '0;
        end else if (take) begin
            stgValid_r <= 1'b1;
            stgData_r <= patWord;
        end else if (bufInReady) begin
            stgValid_r <= 1'b0;
        end
    end

    two_entry_buffer #(
        .WIDTH(DATA_W)
    ) uBuffer (
        .clk(clk),
        .arst_n(arst_n),
        .inData(stgData_r),
        .inValid(stgValid_r),
        .inReady(bufInReady),
        .outData(outData),
        .outValid(outValid),
        .outReady(outReady)
    );

endmodule : adc_serial_config

/* File: tb/adc_serial_config_props.sv */
/*
 * Port-level checker for the converter configuration bank.
 * Assumes it is bound to adc_serial_config and that everything it watches
 * lives in the single clk domain with arst_n as its reset.
 */
module adc_serial_config_props
    import adc_cfg_pkg::*;
#(
    parameter int DATA_W = 14
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire adc_cfg_pkg::ser_pins_t serPins,
    input wire logic resetPin,
    input wire logic adcValid,
    input wire logic adcReady,
    input wire logic overRange,
    input wire logic [DATA_W-1:0] outData,
    input wire logic outValid,
    input wire logic outReady,
    input wire logic overrangeOrReadbackPin,
    input wire adc_cfg_pkg::cfg_t cfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////
    // Cycles since the serial frame and the reset pin went quiet
    logic [3:0] idleCnt_r; // Saturating quiet-time counter
    logic [3:0] idleCnt_nxt; // Restarts on any frame or reset pin
    assign idleCnt_nxt = (!serPins.serialSelectN || resetPin) ? 4'h0 :
        (idleCnt_r == 4'hf) ? idleCnt_r : idleCnt_r + 4'h1;
    // Counter register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) idleCnt_r <= 4'h0;
        else idleCnt_r <= idleCnt_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Steps: pin reset held through sync, and a stalled output
    sequence sPinReset;
        resetPin [*6];
    endsequence
    sequence sStall;
        outValid && !outReady;
    endsequence

    ////////////////////////////////////////////////////////////////////
    // Relations
    a_reset_clears_cfg: assert property (
        sPinReset |-> cfg == '0) else $error("cfg not cleared by reset pin");
    a_reset_pin_ovr: assert property (
        sPinReset |-> overrangeOrReadbackPin == $past(overRange))
        else $error("pin not showing over-range after reset");
    a_offset_gated: assert property (
        cfg.offsetLoopEnable |-> cfg.shortPathOff)
        else $error("offset loop on in low latency mode");
    a_ready_when_empty: assert property (
        !outValid |-> adcReady) else $error("input refused while empty");
    a_valid_held: assert property (
        sStall |=> outValid) else $error("output word dropped in stall");
    a_data_held: assert property (
        sStall |=> $stable(outData)) else $error("output data moved in stall");
    a_first_latency: assert property (
        adcValid && adcReady && !outValid |-> ##2 outValid)
        else $error("sample not out two cycles after accept");
    a_idle_cfg_stable: assert property (
        idleCnt_r >= 4'h8 |=> $stable(cfg))
        else $error("cfg changed with no serial activity");
endmodule : adc_serial_config_props

/* File: tb/adc_host_model.sv */
/*
 * Host side of the three-wire configuration port.
 * Assumes it is the only driver of the serial pins; the serial clock
 * runs at 125 ns only inside frames and idles low.
 */
module adc_host_model
    import adc_cfg_pkg::*;
(
    output adc_cfg_pkg::ser_pins_t serPins,
    input wire logic readPin
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: deselected, clock still
    initial serPins = '{serialSelectN: 1'b1, default: 1'b0};

    ////////////////////////////////////////////////////////////////////
    // One 16-bit word; read-back bits taken at falling edges 9..16
    task automatic xfer(input logic [7:0] addr, input logic [7:0] data,
        output logic [7:0] rd);
        logic [15:0] word;
        word = {addr, data};
        serPins.serialSelectN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            #62.5 serPins.serialClock = 1'b1;
            // Data moves on the rise, half a period clear of the fall
            serPins.serialInLine = word[i];
            #62.5;
            // Sample just before the fall, as a real host latches it
            if (i < 8) rd[i] = readPin;
            serPins.serialClock = 1'b0;
        end
        #62.5 serPins.serialSelectN = 1'b1;
        // Released line must not keep the last bit
        serPins.serialInLine = ~serPins.serialInLine;
    endtask : xfer
endmodule : adc_host_model

/* File: tb/adc_serial_config_tb.sv */
/*
 * Self-checking bench for the configuration bank: serial writes and
 * read-back through the host model, pattern and buffer checks on the
 * sample path. Assumes the default 14-bit data width.
 */
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin \
    numErrors++; $display("Error at %0t: got %h exp %h", $time, got, exp); \
    end end

module adc_serial_config_tb
    import adc_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic arst_n;
    ser_pins_t serPins; // Driven by the host model
    logic resetPin;
    logic [13:0] adcData;
    logic adcValid;
    logic adcReady;
    logic overRange = 1'b0; // Toggles every cycle
    logic [13:0] outData;
    logic outValid;
    logic outReady;
    logic pin;
    cfg_t cfg;
    cfg_t snap; // Settings before an unmapped write
    int numErrors = 0;
    int checkCount = 0;
    logic [7:0] rd;
    logic [13:0] q0, q1;
    logic [5:0] swings [5] = '{6'h1b, 6'h32, 6'h14, 6'h3e, 6'h0f};
    logic [2:0] pc [3] = '{PAT_ZEROS, PAT_ONES, PAT_CUSTOM};
    logic [13:0] pe [3] = '{14'h0000, 14'h3fff, 14'h2957};

    adc_serial_config dut (.clk(clk), .arst_n(arst_n), .serPins(serPins),
        .resetPin(resetPin), .adcData(adcData), .adcValid(adcValid),
        .adcReady(adcReady), .overRange(overRange), .outData(outData),
        .outValid(outValid), .outReady(outReady),
        .overrangeOrReadbackPin(pin), .cfg(cfg));
    adc_host_model host (.serPins(serPins), .readPin(pin));

    ////////////////////////////////////////////////////////////////////
    // Clock and over-range stimulus
    initial forever #5 clk = ~clk;
    always @(posedge clk) overRange <= ~overRange;

    // Verdict and end of run
    task automatic stopTest();
        if (numErrors == 0 && checkCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stopTest

    // Register write, then let cfg settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(a, d, rd);
        repeat (4) @(posedge clk);
    endtask : wr

    // Take one output word; a missing word ends the run
    task automatic pop(output logic [13:0] q);
        bit got = 0;
        for (int n = 0; n < 20 && !got; n++) begin
            @(negedge clk);
            got = (outValid === 1'b1);
            q = outData;
            @(posedge clk);
        end
        if (!got) begin numErrors++; stopTest(); end
    endtask : pop

    // Offer one sample, then collect its output word
    task automatic push(input logic [13:0] d, output logic [13:0] q);
        bit got = 0;
        @(posedge clk);
        adcData <= d;
        adcValid <= 1'b1;
        for (int n = 0; n < 20 && !got; n++) begin
            @(negedge clk);
            got = (adcReady === 1'b1);
            @(posedge clk);
        end
        adcValid <= 1'b0;
        if (!got) begin numErrors++; stopTest(); end
        pop(q);
    endtask : push

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        arst_n = 1'b0; resetPin = 1'b0; adcData = '0;
        adcValid = 1'b0; outReady = 1'b1;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(cfg, cfg_t'(0))
        wr(8'h01, 8'hfc);
        `CHK(cfg.swingCode, 6'h00)
        wr(8'h43, 8'h01);
        `CHK(cfg.swingCode, 6'h00)
        wr(8'h43, 8'h53);
        `CHK(cfg.swingCode, 6'h3f)
        `CHK({cfg.fullPowerOff, cfg.outputDriverOff}, 2'b11)
        foreach (swings[i]) begin
            wr(8'h01, {swings[i], 2'b00});
            `CHK(cfg.swingCode, swings[i])
        end
        wr(8'h26, 8'h02);
        `CHK(cfg.clockBufferDoubleDrive, 1'b1)
        `CHK(cfg.dataBufferDoubleDrive, 1'b0)
        wr(8'h26, 8'h01);
        `CHK(cfg.clockBufferDoubleDrive, 1'b0)
        `CHK(cfg.dataBufferDoubleDrive, 1'b1)
        wr(8'h03, 8'h03);
        wr(8'h4a, 8'h01);
        `CHK(cfg.performanceModeOneField, 2'h3)
        `CHK(cfg.performanceModeTwoBit, 1'b1)
        wr(8'h42, 8'h0c);
        wr(8'h3d, 8'he0);
        wr(8'hcf, 8'hbc);
        `CHK({cfg.shortPathOff, cfg.lightSleep}, 2'h3)
        `CHK({cfg.offsetLoopEnable, cfg.dataFormat}, 3'h7)
        `CHK({cfg.offsetLoopHold, cfg.offsetLoopSpeed}, 5'h1f)
        snap = cfg;
        wr(8'h02, 8'hff);
        wr(8'h50, 8'hff);
        `CHK(cfg, snap)
        // Read-back mode: writes blocked, register shifted out
        wr(8'h00, 8'h01);
        wr(8'h26, 8'h02);
        `CHK(cfg.dataBufferDoubleDrive, 1'b1)
        host.xfer(8'h43, 8'h00, rd);
        `CHK(rd, 8'h53)
        wr(8'h00, 8'h00);
        @(negedge clk);
        `CHK(pin, ~overRange)
        // Test patterns with the digital path enabled
        wr(8'h42, 8'h08);
        wr(8'h3f, 8'ha5);
        wr(8'h40, 8'h5c);
        foreach (pc[i]) begin
            wr(8'h25, {5'h00, pc[i]});
            push(14'h0123, q0);
            `CHK(q0, pe[i])
        end
        wr(8'h25, 8'h03);
        push(14'h0123, q0);
        push(14'h0123, q1);
        `CHK(q0 ^ q1, 14'h3fff)
        `CHK(q0 == 14'h1555 || q0 == 14'h2aaa, 1'b1)
        wr(8'h25, 8'h04);
        push(14'h0123, q0);
        push(14'h0123, q1);
        `CHK(q1, q0 + 14'h0001)
        wr(8'h25, 8'hc8);
        push(14'h0123, q0);
        `CHK(q0, 14'h0123)
        wr(8'h25, 8'h00);
        push(14'h2345, q0);
        `CHK(q0, 14'h2345)
        // Full 6 dB is about 1.995 times, truncated toward minus infinity
        wr(8'h25, 8'hc0);
        push(14'h0100, q0);
        `CHK(q0, 14'h01fe)
        wr(8'h42, 8'h00);
        `CHK(cfg.offsetLoopEnable, 1'b0)
        wr(8'h25, 8'h01);
        push(14'h0123, q0);
        `CHK(q0, 14'h0123)
        // Stall: three words fit, the fourth is refused
        @(posedge clk);
        outReady <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            adcData <= 14'h0100 + i[13:0];
            adcValid <= 1'b1;
            @(negedge clk);
            `CHK(adcReady, i < 3)
            @(posedge clk);
        end
        adcValid <= 1'b0;
        outReady <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            pop(q0);
            `CHK(q0, 14'h0100 + i[13:0])
        end
        // Software reset, then the bank accepts writes again
        wr(8'h00, 8'h02);
        `CHK(cfg, cfg_t'(0))
        wr(8'h26, 8'h01);
        `CHK(cfg.dataBufferDoubleDrive, 1'b1)
        resetPin <= 1'b1;
        repeat (8) @(posedge clk);
        resetPin <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(cfg, cfg_t'(0))
        stopTest();
    end
endmodule : adc_serial_config_tb

bind adc_serial_config adc_serial_config_props #(.DATA_W(DATA_W)) props (
    .clk(clk), .arst_n(arst_n), .serPins(serPins), .resetPin(resetPin),
    .adcValid(adcValid), .adcReady(adcReady), .overRange(overRange),
    .outData(outData), .outValid(outValid), .outReady(outReady),
    .overrangeOrReadbackPin(overrangeOrReadbackPin), .cfg(cfg));
